// ### core/fse_bus_if.sv
// Bundle between the controller and its flash bus cycle engine.
// Assumes one clock domain; the engine owns the flash pins except fl_reset_n.
`timescale 1ns/1ps
interface fse_bus_if;
  logic        req;
  logic        wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctl (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface

// ### core/fse_cycle.sv
// Flash bus cycle engine: one asynchronous write or read per request.
// Assumes strobe width set by the timing register, in pclk cycles.
`timescale 1ns/1ps
`include "fse_defs.svh"
module fse_cycle #(
  parameter int AW = 22
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic [7:0] strobe_cycles,
  fse_bus_if.eng          bus,
  output logic [AW-1:0]   fl_addr,
  output logic [15:0]     fl_dq_out,
  output logic            fl_dq_oe,
  input  wire logic [15:0] fl_dq_in,
  output logic            fl_we_n,
  output logic            fl_oe_n,
  output logic            fl_ce_n
);
  typedef enum logic [1:0] {FSE_CY_IDLE, FSE_CY_SETUP, FSE_CY_STROBE,
                            FSE_CY_HOLD} fse_cy_t;
  fse_cy_t         st, next_st;
  logic [7:0]      cnt, next_cnt;
  logic [AW-1:0]   next_addr;
  logic [15:0]     next_dq_out, next_rdata;
  logic            next_oe, next_we_n, next_rd_n, next_ce_n, next_done;

  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_addr   = fl_addr;
    next_dq_out = fl_dq_out;
    next_oe     = fl_dq_oe;
    next_we_n   = fl_we_n;
    next_rd_n   = fl_oe_n;
    next_ce_n   = fl_ce_n;
    next_rdata  = bus.rdata;
    next_done   = 1'b0;
    unique case (st)
      FSE_CY_IDLE: if (bus.req) begin
        next_addr   = bus.addr[AW-1:0];
        next_dq_out = bus.wdata;
        next_oe     = bus.wr;
        next_ce_n   = 1'b0;
        next_st     = FSE_CY_SETUP;
      end
      FSE_CY_SETUP: begin
        next_we_n = ~bus.wr;
        next_rd_n = bus.wr;
        next_cnt  = strobe_cycles;
        next_st   = FSE_CY_STROBE;
      end
      FSE_CY_STROBE: if (cnt == 8'h00) begin
        // Data latches on the rising write strobe
        next_we_n  = 1'b1;
        next_rd_n  = 1'b1;
        next_rdata = fl_dq_in;
        next_st    = FSE_CY_HOLD;
      end else begin
        next_cnt = cnt - 8'h01;
      end
      FSE_CY_HOLD: begin
        next_oe   = 1'b0;
        next_ce_n = 1'b1;
        next_done = 1'b1;
        next_st   = FSE_CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= FSE_CY_IDLE;
      cnt       <= 8'h00;
      fl_addr   <= '0;
      fl_dq_out <= 16'h0000;
      fl_dq_oe  <= 1'b0;
      fl_we_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_ce_n   <= 1'b1;
      bus.rdata <= 16'h0000;
      bus.done  <= 1'b0;
    end else if (clk_en) begin
      st        <= next_st;
      cnt       <= next_cnt;
      fl_addr   <= next_addr;
      fl_dq_out <= next_dq_out;
      fl_dq_oe  <= next_oe;
      fl_we_n   <= next_we_n;
      fl_oe_n   <= next_rd_n;
      fl_ce_n   <= next_ce_n;
      bus.rdata <= next_rdata;
      bus.done  <= next_done;
    end
  end
endmodule

// ### core/fse_defs.svh
// Constants of the flash erase host controller: register map and codes.
// Assumes inclusion by bare name from files that need them.
`ifndef FSE_DEFS_SVH
`define FSE_DEFS_SVH
`define FSE_REG_CTRL      12'h000
`define FSE_REG_SECTOR    12'h004
`define FSE_REG_STATUS    12'h008
`define FSE_REG_RDATA     12'h00C
`define FSE_REG_TIMING    12'h010
`define FSE_ADDR_UNLOCK1  12'h555
`define FSE_ADDR_UNLOCK2  12'h2AA
`define FSE_DATA_UNLOCK1  8'hAA
`define FSE_DATA_UNLOCK2  8'h55
`define FSE_DATA_SETUP    8'h80
`define FSE_DATA_SECTOR   8'h30
`define FSE_DATA_SUSPEND  8'hB0
`define FSE_DATA_RESUME   8'h30
`define FSE_DATA_ABORTRST 8'hF0
`define FSE_DATA_IDENTRY  8'h90
`define FSE_DATA_RESET    8'hF0
`define FSE_PROT_OFFSET   8'h02
`define FSE_WINDOW_US     50
`define FSE_RESET_NS      500
`define FSE_CLK_NS        40
`define FSE_TIMING_RST    8'h03
`define FSE_CMD_W         3
`endif

// ### core/fse_host.sv
// Host controller issuing sector erase, suspend and resume to a NOR flash.
// Assumes APB software access and a flash on the fl_* pins, clockless.
//
// Operation
// - Erase opens with two unlocks, 80h, two unlocks, sector plus 30h.
// - Extra sector writes must follow each other within 50 us.
// - Queue sectors without interruption so none misses the window.
// - Other writes in the window cancel erase; host must reissue all.
// - Hardware reset aborts erase; host reissues the whole sequence.
// - Resume is 30h at the suspended sector; new suspend allowed after.
// - Abort recovery is unlock 555, unlock 2AA, F0h at 555.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "fse_defs.svh"
module fse_host #(
  parameter int AW       = 22,
  parameter int SA_LSB   = 15,
  parameter int CLK_NS   = `FSE_CLK_NS,
  parameter int WIN_US   = `FSE_WINDOW_US,
  parameter int RST_NS   = `FSE_RESET_NS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [AW-1:0]    fl_addr,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_we_n,
  output logic             fl_oe_n,
  output logic             fl_ce_n,
  output logic             fl_reset_n,
  input  wire logic        ready_busy_n
);
  import fse_pkg::*;

  // Window count rounds down so the host never crosses it
  localparam int WIN_CYC = (WIN_US * 1000) / CLK_NS;
  localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW      = $clog2(WIN_CYC + 1);

  typedef enum logic [2:0] {FSE_S_IDLE, FSE_S_SEQ, FSE_S_WAIT,
                            FSE_S_READ, FSE_S_RESET} fse_state_t;

  fse_bus_if bus ();

  //////////////////////////////////////////////////////////////////////
  // Register file
  logic [AW-1:0]  sector, next_sector;
  logic [7:0]     timing, next_timing;
  logic [15:0]    rdata_q, next_rdata_q;
  fse_op_t        op, next_op;
  logic           busy, next_busy;
  logic           late, next_late;
  logic           suspended, next_suspended;
  logic [31:0]    next_prdata;
  logic           next_pready, next_pslverr;
  logic           go;

  function automatic logic [AW-1:0] sect_addr(input logic [AW-1:0] sa,
                                              input logic [7:0] off);
    sect_addr = {sa[AW-1:SA_LSB], {(SA_LSB-8){1'b0}}, off};
  endfunction

  function automatic logic [AW-1:0] unlock(input logic [11:0] a);
    // High address bits are don't care on unlock cycles
    unlock = {{(AW-12){1'b0}}, a};
  endfunction

  // Writes land at the access edge, where the master samples pready
  assign go = psel && penable && pready && pwrite &&
              paddr == `FSE_REG_CTRL && !busy;

  always_comb begin
    next_sector  = sector;
    next_timing  = timing;
    next_op      = op;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && penable && pready && pwrite) begin
      unique case (paddr)
        `FSE_REG_CTRL:   if (!busy) next_op =
                           fse_op_t'(pwdata[`FSE_CMD_W-1:0]);
        `FSE_REG_SECTOR: next_sector = pwdata[AW-1:0];
        `FSE_REG_TIMING: next_timing = pwdata[7:0];
        default: ;
      endcase
    end
    if (psel && !penable) begin
      next_pready = 1'b1;
      if (pwrite) begin
        unique case (paddr)
          `FSE_REG_CTRL, `FSE_REG_SECTOR, `FSE_REG_TIMING: ;
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          `FSE_REG_CTRL:   next_prdata = {29'h0, op};
          `FSE_REG_SECTOR: next_prdata = {{(32-AW){1'b0}}, sector};
          `FSE_REG_STATUS: next_prdata = {27'h0, ~ready_busy_n, 1'b0,
                                          suspended, late, busy};
          `FSE_REG_RDATA:  next_prdata = {16'h0, rdata_q};
          `FSE_REG_TIMING: next_prdata = {24'h0, timing};
          default: begin
            next_prdata  = 32'h0;
            next_pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Command sequencer
  fse_state_t     st, next_st;
  logic [2:0]     idx, next_idx;
  logic [CW-1:0]  wcnt, next_wcnt;
  logic           next_rst_n;
  logic           next_req, next_wr;
  logic [AW-1:0]  next_baddr;
  logic [15:0]    next_bwdata;
  logic [2:0]     seq_len;
  logic [AW-1:0]  s_addr;
  logic [7:0]     s_data;

  // Each op is a short table of address and data words
  always_comb begin
    s_addr  = unlock(`FSE_ADDR_UNLOCK1);
    s_data  = `FSE_DATA_UNLOCK1;
    seq_len = 3'd1;
    unique case (op)
      FSE_OP_ERASE: begin
        seq_len = 3'd6;
        unique case (idx)
          3'd1, 3'd4: begin
            s_addr = unlock(`FSE_ADDR_UNLOCK2);
            s_data = `FSE_DATA_UNLOCK2;
          end
          3'd2: s_data = `FSE_DATA_SETUP;
          3'd5: begin
            s_addr = sect_addr(sector, 8'h00);
            s_data = `FSE_DATA_SECTOR;
          end
          default: ;
        endcase
      end
      FSE_OP_ADD_SECTOR, FSE_OP_RESUME: begin
        s_addr = sect_addr(sector, 8'h00);
        s_data = `FSE_DATA_SECTOR;
      end
      FSE_OP_SUSPEND: begin
        s_addr = sect_addr(sector, 8'h00);
        s_data = `FSE_DATA_SUSPEND;
      end
      FSE_OP_ABORT_RESET, FSE_OP_PROT_VERIFY: begin
        seq_len = 3'd3;
        if (idx == 3'd1) begin
          s_addr = unlock(`FSE_ADDR_UNLOCK2);
          s_data = `FSE_DATA_UNLOCK2;
        end else if (idx == 3'd2) begin
          s_data = (op == FSE_OP_ABORT_RESET) ? `FSE_DATA_ABORTRST
                                              : `FSE_DATA_IDENTRY;
        end
      end
      default: ;
    endcase
  end

  always_comb begin
    next_st        = st;
    next_idx       = idx;
    next_wcnt      = wcnt;
    next_busy      = busy;
    next_late      = late;
    next_suspended = suspended;
    next_rst_n     = fl_reset_n;
    next_rdata_q   = rdata_q;
    next_req       = 1'b0;
    next_wr        = bus.wr;
    next_baddr     = bus.addr;
    next_bwdata    = bus.wdata;
    if (wcnt != '0) next_wcnt = wcnt - CW'(1);
    unique case (st)
      FSE_S_IDLE: if (go) begin
        next_busy = 1'b1;
        next_idx  = 3'd0;
        next_late = 1'b0;
        // Late add: window may have closed, so the sector can be lost
        if (next_op == FSE_OP_ADD_SECTOR && wcnt == '0)
          next_late = 1'b1;
        // Hardware reset is the only way to stop a running erase
        if (next_op == FSE_OP_RESET) begin
          next_rst_n = 1'b0;
          next_wcnt  = CW'(RST_CYC);
          next_st    = FSE_S_RESET;
        end else if (next_op != FSE_OP_NONE) begin
          next_st = FSE_S_SEQ;
        end else begin
          next_busy = 1'b0;
        end
      end
      FSE_S_SEQ: begin
        next_req    = 1'b1;
        next_wr     = 1'b1;
        next_baddr  = s_addr;
        next_bwdata = {8'h00, s_data};
        next_st     = FSE_S_WAIT;
      end
      FSE_S_WAIT: if (bus.done) begin
        if (idx + 3'd1 < seq_len) begin
          next_idx = idx + 3'd1;
          next_st  = FSE_S_SEQ;
        end else if (op == FSE_OP_PROT_VERIFY) begin
          next_req   = 1'b1;
          next_wr    = 1'b0;
          next_baddr = sect_addr(sector, `FSE_PROT_OFFSET);
          next_st    = FSE_S_READ;
        end else begin
          if (op == FSE_OP_ERASE || op == FSE_OP_ADD_SECTOR ||
              op == FSE_OP_RESUME)
            next_wcnt = CW'(WIN_CYC);
          if (op == FSE_OP_SUSPEND) next_suspended = 1'b1;
          if (op == FSE_OP_RESUME)  next_suspended = 1'b0;
          next_busy = 1'b0;
          next_st   = FSE_S_IDLE;
        end
      end
      FSE_S_READ: if (bus.done) begin
        next_rdata_q = bus.rdata;
        next_busy    = 1'b0;
        next_st      = FSE_S_IDLE;
      end
      FSE_S_RESET: if (wcnt == '0) begin
        next_rst_n     = 1'b1;
        next_suspended = 1'b0;
        next_busy      = 1'b0;
        next_st        = FSE_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector     <= '0;
      timing     <= `FSE_TIMING_RST;
      op         <= FSE_OP_NONE;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      st         <= FSE_S_IDLE;
      idx        <= 3'd0;
      wcnt       <= '0;
      busy       <= 1'b0;
      late       <= 1'b0;
      suspended  <= 1'b0;
      fl_reset_n <= 1'b1;
      rdata_q    <= 16'h0;
      bus.req    <= 1'b0;
      bus.wr     <= 1'b0;
      bus.addr   <= '0;
      bus.wdata  <= 16'h0;
    end else if (clk_en) begin
      sector     <= next_sector;
      timing     <= next_timing;
      op         <= next_op;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      st         <= next_st;
      idx        <= next_idx;
      wcnt       <= next_wcnt;
      busy       <= next_busy;
      late       <= next_late;
      suspended  <= next_suspended;
      fl_reset_n <= next_rst_n;
      rdata_q    <= next_rdata_q;
      bus.req    <= next_req;
      bus.wr     <= next_wr;
      bus.addr   <= next_baddr;
      bus.wdata  <= next_bwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  fse_cycle #(.AW(AW)) u_cycle (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .strobe_cycles (timing),
    .bus           (bus),
    .fl_addr       (fl_addr),
    .fl_dq_out     (fl_dq_out),
    .fl_dq_oe      (fl_dq_oe),
    .fl_dq_in      (fl_dq_in),
    .fl_we_n       (fl_we_n),
    .fl_oe_n       (fl_oe_n),
    .fl_ce_n       (fl_ce_n)
  );
endmodule

// ### core/fse_pkg.sv
// Types shared by the flash erase host controller and its testbench.
// Assumes fse_defs.svh sits in the include path.
package fse_pkg;
  typedef enum logic [2:0] {
    FSE_OP_NONE,
    FSE_OP_ERASE,
    FSE_OP_ADD_SECTOR,
    FSE_OP_SUSPEND,
    FSE_OP_RESUME,
    FSE_OP_ABORT_RESET,
    FSE_OP_PROT_VERIFY,
    FSE_OP_RESET
  } fse_op_t;
endpackage

// ### tb/fse_flash_model.sv
// Behavioural NOR flash: sector erase window, suspend, resume, protect read.
// Assumes pclk only as a timebase; commands latch on write strobe rise.
`timescale 1ns/1ps
module fse_flash_model #(
  parameter int WIN_CYC   = 1250,
  parameter int ERASE_CYC = 3000,
  parameter int SUSP_CYC  = 125
) (
  input  wire logic        pclk,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq,
  output logic [15:0]      dq_dev,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ce_n,
  input  wire logic        reset_n,
  output logic             ready_busy_n
);
  typedef enum logic [2:0] {FSE_FM_READ, FSE_FM_WIN, FSE_FM_ERASE,
                            FSE_FM_HALT, FSE_FM_SUSP} fse_fm_state_t;
  fse_fm_state_t st = FSE_FM_READ;
  int            step = 0;
  int            cnt = 0;
  logic          id_mode = 1'b0;
  logic          tog = 1'b0;
  logic          pat = 1'b0;
  logic [6:0]    sect = 7'h00;
  logic [7:0]    d;
  always @(posedge we_n) begin
    d = dq[7:0];
    if (!ce_n && reset_n) begin
      case (st)
        FSE_FM_WIN: begin
          if (d == 8'h30) cnt = 0;
          else if (d == 8'hB0) st = FSE_FM_SUSP;
          else st = FSE_FM_READ;
        end
        FSE_FM_ERASE: if (d == 8'hB0) begin
          st = FSE_FM_HALT;
          cnt = 0;
        end
        FSE_FM_HALT: ;
        default: begin
          if (d == 8'hF0) id_mode = 1'b0;
          if (st == FSE_FM_SUSP && step == 0 && d == 8'h30 && addr[21:15] == sect) begin
            st = FSE_FM_ERASE;
            cnt = 0;
          end
          else if (step == 0 || step == 3) step = (addr[11:0] == 12'h555 && d == 8'hAA) ? step + 1 : 0;
          else if (step == 1 || step == 4) step = (addr[11:0] == 12'h2AA && d == 8'h55) ? step + 1 : 0;
          else if (step == 2) begin
            if (d == 8'h90) id_mode = 1'b1;
            step = (d == 8'h80 && st == FSE_FM_READ) ? 3 : 0;
          end else begin
            step = 0;
            if (d == 8'h30) begin
              st = FSE_FM_WIN;
              sect = addr[21:15];
              cnt = 0;
            end
          end
        end
      endcase
    end
  end
  always @(posedge pclk or negedge reset_n) begin
    pat = ~pat;
    if (!reset_n) begin
      st = FSE_FM_READ;
      step = 0;
      id_mode = 1'b0;
    end else begin
      cnt++;
      if (st == FSE_FM_WIN && cnt >= WIN_CYC) begin
        st = FSE_FM_ERASE;
        cnt = 0;
      end
      else if (st == FSE_FM_ERASE && cnt >= ERASE_CYC) st = FSE_FM_READ;
      else if (st == FSE_FM_HALT && cnt >= SUSP_CYC) st = FSE_FM_SUSP;
    end
  end
  always @(negedge oe_n) tog = ~tog;
  assign ready_busy_n = !(st inside {FSE_FM_WIN, FSE_FM_ERASE, FSE_FM_HALT});
  // Released bus shows a changing pattern, never the last value
  always_comb begin
    dq_dev = {16{pat}};
    if (!oe_n && !ce_n) begin
      if (id_mode && addr[7:0] == 8'h02) dq_dev = {15'h0, addr[15]};
      else if (st != FSE_FM_READ && addr[21:15] == sect) begin
        dq_dev = {8'h00, st == FSE_FM_SUSP, st != FSE_FM_SUSP && tog, 2'b00,
                  st != FSE_FM_WIN, tog, 2'b00};
      end else dq_dev = 16'hC3A5;
    end
  end
endmodule

// ### tb/fse_host_props.sv
// Checker for the flash erase host: APB answer and flash strobe shape.
// Assumes one clock domain; sees only the top module's ports.
`timescale 1ns/1ps
`include "fse_defs.svh"
module fse_host_props #(
  parameter int AW     = 22,
  parameter int CLK_NS = 40,
  parameter int RST_NS = 500
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0]   fl_dq_out,
  input wire logic          fl_dq_oe,
  input wire logic          fl_we_n,
  input wire logic          fl_oe_n,
  input wire logic          fl_ce_n,
  input wire logic          fl_reset_n
);
  localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
  logic [7:0] tim, next_tim, we_cnt, next_we_cnt, rst_cnt, next_rst_cnt;
  logic       mapped;
  // Status and read data are read only, so writes there are errors
  assign mapped = pwrite ?
                  (paddr inside {`FSE_REG_CTRL, `FSE_REG_SECTOR,
                                 `FSE_REG_TIMING}) :
                  (paddr inside {`FSE_REG_CTRL, `FSE_REG_SECTOR,
                                 `FSE_REG_STATUS, `FSE_REG_RDATA,
                                 `FSE_REG_TIMING});
  // Mirror of the strobe length register, so widths can be judged
  always_comb begin
    next_tim = tim;
    if (psel && penable && pready && pwrite && paddr == `FSE_REG_TIMING) begin
      next_tim = pwdata[7:0];
    end
    next_we_cnt  = fl_we_n ? 8'h00 : we_cnt + 8'h01;
    next_rst_cnt = fl_reset_n ? 8'h00 : rst_cnt + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim     <= `FSE_TIMING_RST;
      we_cnt  <= 8'h00;
      rst_cnt <= 8'h00;
    end else begin
      tim     <= next_tim;
      we_cnt  <= next_we_cnt;
      rst_cnt <= next_rst_cnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_no_wait: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (psel && !penable |=> pslverr != $past(mapped))
    else $error("pslverr wrong");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_we_width: assert property ($rose(fl_we_n) |-> we_cnt == tim + 8'h01)
    else $error("write strobe width");
  // Pin stays low one cycle past the rounded-up count
  a_reset_width: assert property ($rose(fl_reset_n) |-> rst_cnt == RST_CYC + 1)
    else $error("flash reset width");
  a_write_shape: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write cycle shape");
  a_cmd_byte: assert property (!fl_we_n |-> fl_dq_out[15:8] == 8'h00)
    else $error("command high byte");
  a_write_hold: assert property (!fl_we_n ##1 !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("write data moved");
  a_read_release: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("drive during read");
endmodule
bind fse_host fse_host_props #(.AW(AW), .CLK_NS(CLK_NS), .RST_NS(RST_NS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
  .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n), .fl_reset_n(fl_reset_n));

// ### tb/tb.sv
// Bench for the flash erase host: APB orders against a flash model.
// Assumes the design files and fse_defs.svh on the include path.
`timescale 1ns/1ps
`include "fse_defs.svh"
module tb;
  import fse_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        fl_dq_oe, fl_we_n, fl_oe_n, fl_ce_n, fl_reset_n, ready_busy_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out, dq_dev, dq_wire;
  logic [29:0] wlog[$];
  logic [20:0] exp_q[$];
  logic [6:0]  s1, s2;
  logic        err;
  int          miscompares = 0, num_checks = 0, cycles = 0, seed = 9, n;
  assign dq_wire = fl_dq_oe ? fl_dq_out : dq_dev;
  fse_host uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(dq_wire),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ce_n(fl_ce_n),
    .fl_reset_n(fl_reset_n), .ready_busy_n(ready_busy_n));
  fse_flash_model u_flash (.pclk(pclk), .addr(fl_addr), .dq(dq_wire),
    .dq_dev(dq_dev), .we_n(fl_we_n), .oe_n(fl_oe_n), .ce_n(fl_ce_n),
    .reset_n(fl_reset_n), .ready_busy_n(ready_busy_n));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end
  always @(posedge fl_we_n) if (presetn) wlog.push_back({fl_addr, fl_dq_out[7:0]});
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready; the cycle ceiling ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic void push(input logic sa, input logic [11:0] a, input logic [7:0] d);
    exp_q.push_back({sa, a, d});
  endfunction
  // Expected flash write cycles of each order
  function automatic void build(input fse_op_t op);
    exp_q.delete();
    if (op inside {FSE_OP_ERASE, FSE_OP_ABORT_RESET, FSE_OP_PROT_VERIFY}) begin
      push(1'b0, 12'h555, 8'hAA);
      push(1'b0, 12'h2AA, 8'h55);
    end
    case (op)
      FSE_OP_ERASE: begin
        push(1'b0, 12'h555, 8'h80);
        push(1'b0, 12'h555, 8'hAA);
        push(1'b0, 12'h2AA, 8'h55);
        push(1'b1, 12'h000, 8'h30);
      end
      FSE_OP_ADD_SECTOR, FSE_OP_RESUME: push(1'b1, 12'h000, 8'h30);
      FSE_OP_SUSPEND: push(1'b1, 12'h000, 8'hB0);
      FSE_OP_ABORT_RESET: push(1'b0, 12'h555, 8'hF0);
      FSE_OP_PROT_VERIFY: push(1'b0, 12'h555, 8'h90);
      default: ;
    endcase
  endfunction
  task automatic do_op(input fse_op_t op, input logic [6:0] s);
    logic [29:0] e;
    apb(1'b1, `FSE_REG_SECTOR, {10'h0, s, 15'h0});
    build(op);
    wlog.delete();
    apb(1'b1, `FSE_REG_CTRL, {29'h0, op});
    n = 0;
    do begin
      apb(1'b0, `FSE_REG_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (op != FSE_OP_PROT_VERIFY) chk("write count", 32'(wlog.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      e = (i < wlog.size()) ? wlog[i] : '1;
      if (exp_q[i][20]) chk("sector write", {e[29:23], e[7:0]}, {s, exp_q[i][7:0]});
      else chk("unlock write", {e[19:8], e[7:0]}, exp_q[i][19:0]);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FSE_REG_TIMING, 32'h0);
    chk("timing reset", rd, 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    rs = $random(seed);
    apb(1'b1, `FSE_REG_TIMING, {30'h0, rs[1:0]});
    apb(1'b0, `FSE_REG_TIMING, 32'h0);
    chk("timing", rd, {30'h0, rs[1:0]});
    $display("test registers done");
    s1 = 7'($random(seed));
    s2 = s1 ^ 7'h01;
    do_op(FSE_OP_ERASE, s1);
    chk("erase busy late", {rd[4], rd[1]}, 32'h2);
    do_op(FSE_OP_ADD_SECTOR, s2);
    chk("window late", rd[1], 32'h0);
    do_op(FSE_OP_SUSPEND, s1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `FSE_REG_STATUS, 32'h0);
    chk("suspended", {rd[4], rd[2]}, 32'h1);
    do_op(FSE_OP_PROT_VERIFY, {s1[6:1], 1'b1});
    apb(1'b0, `FSE_REG_RDATA, 32'h0);
    chk("protect set", rd, 32'h1);
    $display("test erase and suspend done");
    do_op(FSE_OP_RESUME, s1);
    chk("resumed busy", rd[4], 32'h1);
    repeat (1300) @(posedge pclk);
    do_op(FSE_OP_ADD_SECTOR, s2);
    chk("late add", rd[1], 32'h1);
    n = 0;
    do begin
      repeat (50) @(posedge pclk);
      apb(1'b0, `FSE_REG_STATUS, 32'h0);
      n++;
    end while (rd[4] !== 1'b0 && n < 100);
    chk("erase done", rd[4], 32'h0);
    $display("test resume done");
    do_op(FSE_OP_ABORT_RESET, 7'h00);
    do_op(FSE_OP_ERASE, s2);
    do_op(FSE_OP_RESET, 7'h00);
    chk("reset abort", rd[4], 32'h0);
    do_op(FSE_OP_PROT_VERIFY, {s2[6:1], 1'b0});
    apb(1'b0, `FSE_REG_RDATA, 32'h0);
    chk("protect clear", rd, 32'h0);
    $display("test abort and reset done");
    report_and_stop();
  end
endmodule
